/* core/dtp_pkg.sv */
// package for the dead-time / phase-shift pwm channel pair
// assumes one count clock shared by every counter of the pair
package dtp_pkg;
  localparam int CNT_W = 16;
  typedef logic [CNT_W-1:0] dtp_word_t;
  localparam dtp_word_t CNT_RST = 16'h0000;
  localparam dtp_word_t CMP_RST = 16'h0000;
  localparam dtp_word_t TOP_RST = 16'hffff;
  localparam dtp_word_t BOT_RST = 16'h0000;
  localparam dtp_word_t DEAD_START = 16'h0000;
  localparam dtp_word_t CNT_STEP = 16'h0001;
  localparam logic [CNT_W:0] WRAP_EXTRA = 17'h00001;
  localparam logic OUT_RST = 1'b0;
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_LOW = 2'h1,
    ACT_HIGH = 2'h2,
    ACT_TOGGLE = 2'h3
  } dtp_act_t;
  typedef enum logic [1:0] {
    MODE_PLAIN = 2'h0,
    MODE_DEAD = 2'h1,
    MODE_PHASE = 2'h2,
    MODE_PHASE_DEAD = 2'h3
  } dtp_mode_t;
  typedef enum logic [1:0] {
    DIR_UP = 2'b01,
    DIR_DOWN = 2'b10
  } dtp_dir_t;
  typedef enum logic [2:0] {
    SEL_A = 3'h0,
    SEL_B = 3'h1,
    SEL_C = 3'h2,
    SEL_D = 3'h3,
    SEL_TOP = 3'h4,
    SEL_BOTTOM = 3'h5
  } dtp_sel_t;
endpackage

/* core/dtp_level_act.sv */
// next level of one pwm output from two programmable actions
// assumes the caller registers the result; second action outranks first
`timescale 1ns/1ps
module dtp_level_act (
  input wire logic level_in,
  input wire logic first_ev_in,
  input wire dtp_pkg::dtp_act_t first_act_in,
  input wire logic second_ev_in,
  input wire dtp_pkg::dtp_act_t second_act_in,
  output logic level_out
);
  import dtp_pkg::*;

  function automatic logic apply_act(input logic cur, input dtp_act_t act);
    case (act)
      ACT_LOW: apply_act = 1'b0;
      ACT_HIGH: apply_act = 1'b1;
      ACT_TOGGLE: apply_act = ~cur;
      default: apply_act = cur;
    endcase
  endfunction

  always_comb begin
    level_out = level_in; // R24
    if (second_ev_in) begin
      level_out = apply_act(level_in, second_act_in); // R07
    end else if (first_ev_in) begin
      level_out = apply_act(level_in, first_act_in); // R07
    end
  end
endmodule // dtp_level_act

/* core/dtp_dead_counter.sv */
// one dead-time counter: starts from zero, ends on its limit or a stop
// assumes clk_en_in is the shared count tick
`timescale 1ns/1ps
module dtp_dead_counter (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic start_in,
  input wire logic use_limit_in,
  input wire dtp_pkg::dtp_word_t limit_in,
  input wire logic stop_in,
  output dtp_pkg::dtp_word_t count_out,
  output logic running_out,
  output logic done_out
);
  import dtp_pkg::*;

  dtp_word_t count_q;
  logic run_q;

  assign count_out = count_q;
  assign running_out = run_q;
  assign done_out = use_limit_in ? (run_q && count_q == limit_in) : stop_in; // R11

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      count_q <= DEAD_START;
      run_q <= 1'b0;
    end else if (clk_en_in) begin // R20
      if (start_in) begin
        // a fresh start while running stretches the dead time
        count_q <= DEAD_START; // R09 R10
        run_q <= 1'b1;
      end else if (done_out) begin
        count_q <= DEAD_START; // R03 R05
        run_q <= 1'b0;
      end else if (run_q) begin
        count_q <= count_q + CNT_STEP;
      end
    end
  end

  default clocking dcb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  chk_dead_restart: assert property (clk_en_in && start_in |=> run_q && count_q == DEAD_START) // R10
    else $error("dead counter did not restart from zero");
  chk_dead_stop: assert property (clk_en_in && done_out && !start_in |=> !run_q && count_q == DEAD_START) // R03
    else $error("dead counter not cleared and stopped");
  chk_dead_zero: assert property (clk_en_in && start_in && use_limit_in && limit_in == DEAD_START
      ##1 clk_en_in && !start_in |=> !run_q) // R11
    else $error("zero dead time not one cycle");
endmodule // dtp_dead_counter

/* core/dtp_pwm_core.sv */
// complementary pwm pair: period counter, two dead counters, compare file
// assumes clk_en_in is the count tick and software ports are synchronous
// Operation
// R01: up counting runs to top, reloads bottom, keeps counting upward.
// R02: dead mode variant 0, compare A sets low first level, starts dead counter one.
// R03: dead counter one reaching C sets high first level, clears and stops it.
// R04: variant 0 up, compare B sets high second level, starts dead counter two.
// R05: dead counter two reaching D sets low second level, clears and stops it.
// R06: variant 1 swaps which output each of those four events drives.
// R07: each output action is no change, low, high or toggle.
// R08: software writes direct compares forty count cycles plus three cpu clocks early.
// R09: a repeated A or B match before the limit clears the dead counter.
// R10: a repeated start trigger restarts the running dead counter from zero.
// R11: a zero C or D gives a one-cycle dead time.
// R12: up-down counting bounces between top and bottom forever.
// R13: a stopped period counter resumes counting upward.
// R14: up-down dead mode, A going up starts counter one, going down counter two.
// R15: buffered up-down transfer at top turn, bottom turn or both.
// R16: buffered up counting transfers shadows when the counter reloads bottom.
// R17: phase modes are up and buffered only; reload skips B and D.
// R18: phase mode, A match loads B from A plus shadow, C loads D likewise.
// R19: a phase sum above top is reduced by top minus bottom plus one.
// R20: period and dead counters all advance on one count tick.
// R21: phase dead mode variant 0 drives levels and dead counters from matches.
// R22: phase dead mode variant 1 swaps the outputs, same counter starts.
// R23: a direct compare write is used for comparison at once.
// R24: outputs hold between events; no-change leaves them alone.
`timescale 1ns/1ps
module dtp_pwm_core (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic run_in,
  input wire dtp_pkg::dtp_mode_t mode_in,
  input wire logic updown_in,
  input wire logic buffer_mode_in,
  input wire logic adt_variant_in,
  input wire logic load_at_top_in,
  input wire logic load_at_bottom_in,
  input wire dtp_pkg::dtp_act_t act_high_first_in,
  input wire dtp_pkg::dtp_act_t act_high_second_in,
  input wire dtp_pkg::dtp_act_t act_low_first_in,
  input wire dtp_pkg::dtp_act_t act_low_second_in,
  input wire logic wr_en_in,
  input wire logic wr_shadow_in,
  input wire dtp_pkg::dtp_sel_t wr_sel_in,
  input wire dtp_pkg::dtp_word_t wr_data_in,
  output logic high_side_output_out,
  output logic low_side_output_out,
  output dtp_pkg::dtp_word_t period_counter_out,
  output logic counting_down_out,
  output dtp_pkg::dtp_word_t first_dead_counter_out,
  output dtp_pkg::dtp_word_t second_dead_counter_out,
  output dtp_pkg::dtp_word_t compare_b_out,
  output dtp_pkg::dtp_word_t compare_d_out
);
  import dtp_pkg::*;

  dtp_word_t cnt_q;
  dtp_dir_t dir_q;
  dtp_word_t compare_a_q;
  dtp_word_t compare_b_q;
  dtp_word_t compare_c_q;
  dtp_word_t compare_d_q;
  dtp_word_t top_q;
  dtp_word_t bot_q;
  dtp_word_t sh_a_q;
  dtp_word_t sh_b_q;
  dtp_word_t sh_c_q;
  dtp_word_t sh_d_q;
  dtp_word_t sh_top_q;
  dtp_word_t sh_bot_q;
  logic high_q;
  logic low_q;
  logic high_d;
  logic low_d;
  logic phase_mode;
  logic dead_on;
  logic swap;
  logic eff_ud;
  logic eff_buf;
  logic going_up;
  logic at_top;
  logic at_bot;
  logic load_evt;
  logic direct_wr;
  logic m_a;
  logic m_b;
  logic m_c;
  logic m_d;
  logic ev_a;
  logic ev_b;
  logic ev_c;
  logic ev_d;
  logic ev_hf;
  logic ev_hs;
  logic ev_lf;
  logic ev_ls;
  logic d1_done;
  logic d2_done;
  logic d1_run;
  logic d2_run;
  dtp_word_t d1_cnt;
  dtp_word_t d2_cnt;
  dtp_word_t wrap_b;
  dtp_word_t wrap_d;

  // sum of base and offset folded back into the period window
  function automatic dtp_word_t wrap_sum(input dtp_word_t base, input dtp_word_t add,
      input dtp_word_t top, input dtp_word_t bot);
    logic [CNT_W:0] s;
    s = {1'b0, base} + {1'b0, add};
    if (s > {1'b0, top}) begin
      s = s - {1'b0, top} + {1'b0, bot} - WRAP_EXTRA; // R19
    end
    return s[CNT_W-1:0];
  endfunction

  // mode qualification
  assign phase_mode = (mode_in == MODE_PHASE) || (mode_in == MODE_PHASE_DEAD);
  assign dead_on = (mode_in != MODE_PHASE);
  // plain phase mode has no variant: its pairing equals variant 0
  assign swap = adt_variant_in && (mode_in != MODE_PHASE); // R06 R22
  assign eff_ud = updown_in && !phase_mode; // R17
  assign eff_buf = buffer_mode_in || phase_mode; // R17
  assign going_up = (dir_q == DIR_UP);
  assign at_top = (cnt_q == top_q);
  assign at_bot = (cnt_q == bot_q);
  assign direct_wr = wr_en_in && !wr_shadow_in;

  // compares are judged against live registers, so direct writes act at once
  assign m_a = run_in && (cnt_q == compare_a_q); // R23
  assign m_b = run_in && (cnt_q == compare_b_q);
  assign m_c = run_in && (cnt_q == compare_c_q);
  assign m_d = run_in && (cnt_q == compare_d_q);

  // start events for the two dead counters
  assign ev_a = m_a && (!eff_ud || going_up); // R02 R14
  assign ev_b = eff_ud ? (m_a && !going_up) : m_b; // R04 R14
  // ends: dead limit in dead mode, period matches in phase modes
  assign ev_c = phase_mode ? m_c : d1_done; // R03 R21
  assign ev_d = phase_mode ? m_d : d2_done; // R05 R21

  assign ev_hf = swap ? ev_a : ev_c; // R06
  assign ev_hs = swap ? ev_d : ev_b;
  assign ev_lf = swap ? ev_c : ev_a;
  assign ev_ls = swap ? ev_b : ev_d;

  // shadow transfer points
  always_comb begin
    load_evt = 1'b0;
    if (eff_buf && run_in) begin
      if (!eff_ud) begin
        load_evt = at_top; // R16
      end else if (going_up) begin
        load_evt = at_top && load_at_top_in; // R15
      end else begin
        load_evt = at_bot && load_at_bottom_in; // R15
      end
    end
  end

  assign wrap_b = wrap_sum(compare_a_q, sh_b_q, top_q, bot_q);
  assign wrap_d = wrap_sum(compare_c_q, sh_d_q, top_q, bot_q);

  // period counter
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      cnt_q <= CNT_RST;
      dir_q <= DIR_UP;
    end else if (clk_en_in) begin // R20
      if (!run_in) begin
        dir_q <= DIR_UP; // R13
      end else if (!eff_ud) begin
        dir_q <= DIR_UP;
        if (at_top) begin
          cnt_q <= bot_q; // R01
        end else begin
          cnt_q <= cnt_q + CNT_STEP;
        end
      end else begin
        // turning points hold their value for one extra tick
        case (dir_q)
          DIR_UP: begin
            if (at_top) begin
              dir_q <= DIR_DOWN; // R12
            end else begin
              cnt_q <= cnt_q + CNT_STEP;
            end
          end
          DIR_DOWN: begin
            if (at_bot) begin
              dir_q <= DIR_UP; // R12
            end else begin
              cnt_q <= cnt_q - CNT_STEP;
            end
          end
          default: dir_q <= DIR_UP;
        endcase
      end
    end
  end

  // shadow registers
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      sh_a_q <= CMP_RST;
      sh_b_q <= CMP_RST;
      sh_c_q <= CMP_RST;
      sh_d_q <= CMP_RST;
      sh_top_q <= TOP_RST;
      sh_bot_q <= BOT_RST;
    end else if (clk_en_in && wr_en_in && wr_shadow_in) begin
      if (wr_sel_in == SEL_A) begin
        sh_a_q <= wr_data_in;
      end else if (wr_sel_in == SEL_B) begin
        sh_b_q <= wr_data_in;
      end else if (wr_sel_in == SEL_C) begin
        sh_c_q <= wr_data_in;
      end else if (wr_sel_in == SEL_D) begin
        sh_d_q <= wr_data_in;
      end else if (wr_sel_in == SEL_TOP) begin
        sh_top_q <= wr_data_in;
      end else if (wr_sel_in == SEL_BOTTOM) begin
        sh_bot_q <= wr_data_in;
      end
    end
  end

  // live compare registers; a direct write in the same tick wins
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      compare_a_q <= CMP_RST;
      compare_b_q <= CMP_RST;
      compare_c_q <= CMP_RST;
      compare_d_q <= CMP_RST;
      top_q <= TOP_RST;
      bot_q <= BOT_RST;
    end else if (clk_en_in) begin
      if (load_evt) begin
        compare_a_q <= sh_a_q; // R16
        compare_c_q <= sh_c_q;
        top_q <= sh_top_q;
        bot_q <= sh_bot_q;
        if (!phase_mode) begin
          compare_b_q <= sh_b_q;
          compare_d_q <= sh_d_q; // R17
        end
      end
      if (phase_mode && ev_a) begin
        compare_b_q <= wrap_b; // R18 R21
      end
      if (mode_in == MODE_PHASE && m_c) begin
        compare_d_q <= wrap_d; // R18
      end
      if (direct_wr) begin
        if (wr_sel_in == SEL_A) begin
          compare_a_q <= wr_data_in; // R23
        end else if (wr_sel_in == SEL_B) begin
          compare_b_q <= wr_data_in;
        end else if (wr_sel_in == SEL_C) begin
          compare_c_q <= wr_data_in;
        end else if (wr_sel_in == SEL_D) begin
          compare_d_q <= wr_data_in;
        end else if (wr_sel_in == SEL_TOP) begin
          top_q <= wr_data_in;
        end else if (wr_sel_in == SEL_BOTTOM) begin
          bot_q <= wr_data_in;
        end
      end
    end
  end

  dtp_dead_counter u_first_dead (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .start_in(ev_a && dead_on), // R02 R21
    .use_limit_in(!phase_mode),
    .limit_in(compare_c_q),
    .stop_in(m_c),
    .count_out(d1_cnt),
    .running_out(d1_run),
    .done_out(d1_done)
  );

  dtp_dead_counter u_second_dead (
    .ref_clk_in(ref_clk_in),
    .sys_rst_in(sys_rst_in),
    .clk_en_in(clk_en_in),
    .start_in(ev_b && dead_on), // R04 R14
    .use_limit_in(!phase_mode),
    .limit_in(compare_d_q),
    .stop_in(m_d),
    .count_out(d2_cnt),
    .running_out(d2_run),
    .done_out(d2_done)
  );

  dtp_level_act u_high_act (
    .level_in(high_q),
    .first_ev_in(ev_hf),
    .first_act_in(act_high_first_in),
    .second_ev_in(ev_hs),
    .second_act_in(act_high_second_in),
    .level_out(high_d)
  );

  dtp_level_act u_low_act (
    .level_in(low_q),
    .first_ev_in(ev_lf),
    .first_act_in(act_low_first_in),
    .second_ev_in(ev_ls),
    .second_act_in(act_low_second_in),
    .level_out(low_d)
  );

  // output levels are registered, one tick after the match
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      high_q <= OUT_RST;
      low_q <= OUT_RST;
    end else if (clk_en_in) begin
      high_q <= high_d; // R24
      low_q <= low_d;
    end
  end

  assign high_side_output_out = high_q;
  assign low_side_output_out = low_q;
  assign period_counter_out = cnt_q;
  assign counting_down_out = dir_q[1];
  assign first_dead_counter_out = d1_cnt;
  assign second_dead_counter_out = d2_cnt;
  assign compare_b_out = compare_b_q;
  assign compare_d_out = compare_d_q;

  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  chk_up_reload: assert property (clk_en_in && run_in && !eff_ud && at_top |=> cnt_q == $past(bot_q)) // R01
    else $error("up counter did not reload bottom");
  chk_ud_turn: assert property (clk_en_in && run_in && eff_ud && going_up && at_top
      |=> dir_q == DIR_DOWN && cnt_q == $past(cnt_q)) // R12
    else $error("up-down turn at top wrong");
  chk_restart_up: assert property (clk_en_in && !run_in ##1 clk_en_in && run_in && !at_top
      |=> cnt_q == $past(cnt_q) + CNT_STEP) // R13
    else $error("restart not counting up");
  chk_low_first: assert property (clk_en_in && !swap && ev_a && !ev_d && act_low_first_in == ACT_HIGH
      |=> low_side_output_out) // R02
    else $error("low first level not applied");
  chk_high_second: assert property (clk_en_in && !swap && ev_b && act_high_second_in == ACT_LOW
      |=> !high_side_output_out) // R04
    else $error("high second level not applied");
  chk_swap_high: assert property (clk_en_in && swap && ev_a && !ev_d && act_high_first_in == ACT_HIGH
      |=> high_side_output_out) // R06
    else $error("swapped high first level not applied");
  chk_toggle_out: assert property (clk_en_in && ev_hs && act_high_second_in == ACT_TOGGLE
      |=> high_side_output_out != $past(high_side_output_out)) // R07
    else $error("toggle action did not toggle");
  chk_hold_level: assert property (clk_en_in && !ev_hf && !ev_hs |=> $stable(high_side_output_out)) // R24
    else $error("high output changed without event");
  chk_phase_wrap: assert property (clk_en_in && phase_mode && ev_a && !direct_wr
      |=> compare_b_q == $past(wrap_b)) // R18
    else $error("phase compare b not loaded");
  chk_buf_load: assert property (clk_en_in && load_evt && !direct_wr |=> compare_a_q == $past(sh_a_q)) // R16
    else $error("shadow a not transferred");
  chk_ud_noload: assert property (clk_en_in && eff_ud && run_in && going_up && at_top && !load_at_top_in
      && !direct_wr |=> $stable(compare_a_q)) // R15
    else $error("transfer at unselected turn");

  cov_up_reload: cover property (clk_en_in && run_in && !eff_ud && at_top);
  cov_dead_done: cover property (clk_en_in && d1_done && !phase_mode);
  cov_ud_bottom: cover property (clk_en_in && eff_ud && !going_up && at_bot);
  cov_phase_b: cover property (clk_en_in && phase_mode && ev_a);
endmodule // dtp_pwm_core

/* testbench/dtp_gate_model.sv */
// gate driver model for the high and low side power switches
// assumes both gate levels come registered from the pwm pair
`timescale 1ns/1ps
module dtp_gate_model (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic high_gate_in,
  input wire logic low_gate_in,
  output logic [7:0] high_ons_out,
  output logic [7:0] low_ons_out
);
  logic high_q;
  logic low_q;
  // counts turn-on edges only: the power stage reacts to edges
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      high_q <= 1'b0;
      low_q <= 1'b0;
      high_ons_out <= 8'h00;
      low_ons_out <= 8'h00;
    end else begin
      high_q <= high_gate_in;
      low_q <= low_gate_in;
      if (high_gate_in && !high_q) begin
        high_ons_out <= high_ons_out + 8'h01;
      end
      if (low_gate_in && !low_q) begin
        low_ons_out <= low_ons_out + 8'h01;
      end
    end
  end
endmodule // dtp_gate_model

/* testbench/dtp_pwm_core_test.sv */
// self-checking bench for the dead-time / phase-shift pwm pair
// assumes the count tick runs every cycle except where a test freezes it
`timescale 1ns/1ps
module dtp_pwm_core_test;
  import dtp_pkg::*;
  logic clk, rst, ce, run, ud, bm, v, lt, lb, we, ws, hi, lo, dn;
  dtp_mode_t mode;
  dtp_act_t ahf, ahs, alf, als;
  dtp_sel_t sel;
  dtp_word_t wd, cnt, dc1, dc2, cb, cd, hold;
  logic [7:0] ons, lons;
  int bad_count, n_checks, cyc;

  dtp_pwm_core i_dut (.ref_clk_in(clk), .sys_rst_in(rst), .clk_en_in(ce), .run_in(run), .mode_in(mode),
    .updown_in(ud), .buffer_mode_in(bm), .adt_variant_in(v), .load_at_top_in(lt), .load_at_bottom_in(lb),
    .act_high_first_in(ahf), .act_high_second_in(ahs), .act_low_first_in(alf), .act_low_second_in(als),
    .wr_en_in(we), .wr_shadow_in(ws), .wr_sel_in(sel), .wr_data_in(wd), .high_side_output_out(hi),
    .low_side_output_out(lo), .period_counter_out(cnt), .counting_down_out(dn),
    .first_dead_counter_out(dc1), .second_dead_counter_out(dc2), .compare_b_out(cb), .compare_d_out(cd));
  dtp_gate_model i_gate (.ref_clk_in(clk), .sys_rst_in(rst), .high_gate_in(hi), .low_gate_in(lo),
    .high_ons_out(ons), .low_ons_out(lons));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic check(input string what, input dtp_word_t seen, input dtp_word_t exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // strobe dropped a full cycle so back to back calls never collide
  task automatic wr(input dtp_sel_t s, input dtp_word_t d, input logic sh);
    we = 1'b1;
    sel = s;
    wd = d;
    ws = sh;
    tick(1);
    we = 1'b0;
    tick(1);
  endtask

  task automatic wait_cnt(input dtp_word_t x);
    int k;
    k = 0;
    while (cnt !== x && k < 300) begin
      tick(1);
      k++;
    end
    check("counter reach", cnt, x);
  endtask

  // bottom is 5 everywhere; live and shadow get the same values
  task automatic cfg(input dtp_mode_t m, input logic u, input logic b, input logic vv, input dtp_word_t top,
      input dtp_word_t a, input dtp_word_t bb, input dtp_word_t c, input dtp_word_t d);
    dtp_word_t vals [6];
    vals = '{a, bb, c, d, top, 16'h0005};
    rst = 1'b1;
    run = 1'b0;
    mode = m;
    ud = u;
    bm = b;
    v = vv;
    tick(2);
    rst = 1'b0;
    for (int i = 0; i < 12; i++) wr(dtp_sel_t'(i % 6), vals[i % 6], i >= 6);
    // direct compares must settle 3 cpu clocks plus 40 ticks before any match
    tick(43);
    run = 1'b1;
  endtask

  task automatic sides(input logic ea, input logic ec);
    check("a side", 16'(v ? hi : lo), 16'(ea));
    check("c side", 16'(v ? lo : hi), 16'(ec));
  endtask

  task automatic done(input string s);
    $display("test %s done", s);
  endtask

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    run = 1'b0;
    ud = 1'b0;
    bm = 1'b0;
    v = 1'b0;
    lt = 1'b0;
    lb = 1'b0;
    we = 1'b0;
    ws = 1'b0;
    sel = SEL_A;
    wd = 16'h0000;
    mode = MODE_DEAD;
    ahf = ACT_HIGH;
    ahs = ACT_LOW;
    alf = ACT_HIGH;
    als = ACT_LOW;
    bad_count = 0;
    n_checks = 0;
    cyc = 0;
    tick(5);
    rst = 1'b0;
    check("reset out", {14'h0000, hi, lo}, 16'h0000);
    check("reset cnt", cnt, 16'h0000);
    check("reset b", cb, 16'h0000);
    check("reset dir", 16'(dn), 16'h0000);
    done("reset");
    cfg(MODE_DEAD, 1'b0, 1'b0, 1'b0, 16'h0014, 16'h0008, 16'h000e, 16'h0003, 16'h0000);
    hold = cnt;
    ce = 1'b0;
    tick(3);
    check("frozen cnt", cnt, hold);
    ce = 1'b1;
    wait_cnt(16'h0008);
    check("low held", 16'(lo), 16'h0000);
    tick(1);
    check("low at a", 16'(lo), 16'h0001);
    check("dead one", dc1, 16'h0000);
    tick(3);
    check("dead one c", dc1, 16'h0003);
    check("high wait", 16'(hi), 16'h0000);
    tick(1);
    check("high at c", 16'(hi), 16'h0001);
    tick(1);
    check("dead one stop", dc1, 16'h0000);
    wait_cnt(16'h000e);
    tick(1);
    check("high at b", 16'(hi), 16'h0000);
    check("dead two", dc2, 16'h0000);
    tick(1);
    check("low at d0", 16'(lo), 16'h0000);
    check("turn ons", {8'h00, ons}, 16'h0001);
    check("low ons", {8'h00, lons}, 16'h0001);
    wait_cnt(16'h0014);
    tick(1);
    check("reload", cnt, 16'h0005);
    tick(1);
    check("count up", cnt, 16'h0006);
    done("dead up");
    cfg(MODE_DEAD, 1'b0, 1'b0, 1'b0, 16'h0014, 16'h0008, 16'h000e, 16'h000a, 16'h0000);
    wait_cnt(16'h0008);
    tick(1);
    wr(SEL_A, 16'h000b, 1'b0);
    check("dead one run", dc1, 16'h0002);
    tick(1);
    check("dead restart", dc1, 16'h0000);
    tick(10);
    check("high late", 16'(hi), 16'h0000);
    tick(1);
    check("high stretched", 16'(hi), 16'h0001);
    done("restart");
    cfg(MODE_DEAD, 1'b1, 1'b1, 1'b0, 16'h000c, 16'h0006, 16'h0009, 16'h0000, 16'h0002);
    lt = 1'b1;
    wr(SEL_B, 16'h0007, 1'b1);
    wait_cnt(16'h0006);
    tick(1);
    check("low up a", 16'(lo), 16'h0001);
    tick(1);
    check("high up c", 16'(hi), 16'h0001);
    wait_cnt(16'h000c);
    check("b before top", cb, 16'h0009);
    tick(1);
    check("top held", cnt, 16'h000c);
    check("going down", 16'(dn), 16'h0001);
    tick(1);
    check("b at top", cb, 16'h0007);
    check("down count", cnt, 16'h000b);
    lt = 1'b0;
    lb = 1'b1;
    wr(SEL_B, 16'h0004, 1'b1);
    wait_cnt(16'h0006);
    tick(1);
    check("high down a", 16'(hi), 16'h0000);
    check("dead two dn", dc2, 16'h0000);
    check("b no top", cb, 16'h0007);
    tick(2);
    check("low hold", 16'(lo), 16'h0001);
    check("b at bottom", cb, 16'h0004);
    check("up again", 16'(dn), 16'h0000);
    tick(1);
    check("low at d", 16'(lo), 16'h0000);
    wait_cnt(16'h000c);
    tick(2);
    run = 1'b0;
    tick(2);
    run = 1'b1;
    tick(1);
    check("resume up", 16'(dn), 16'h0000);
    check("resume cnt", cnt, 16'h000c);
    done("updown");
    cfg(MODE_DEAD, 1'b0, 1'b1, 1'b0, 16'h0014, 16'h0008, 16'h000e, 16'h0003, 16'h0000);
    wr(SEL_B, 16'h0009, 1'b1);
    wait_cnt(16'h0014);
    check("b kept", cb, 16'h000e);
    tick(1);
    check("b reload", cb, 16'h0009);
    done("buffer up");
    cfg(MODE_PHASE, 1'b1, 1'b0, 1'b0, 16'h0014, 16'h0008, 16'h000f, 16'h000c, 16'h0004);
    wait_cnt(16'h0008);
    tick(1);
    check("b wrapped", cb, 16'h0007);
    check("low at a", 16'(lo), 16'h0001);
    wait_cnt(16'h000c);
    tick(1);
    check("d sum", cd, 16'h0010);
    check("high at c", 16'(hi), 16'h0001);
    wait_cnt(16'h0014);
    tick(1);
    check("phase reload", cnt, 16'h0005);
    check("b not reload", cb, 16'h0007);
    done("phase");
    for (int k = 0; k < 2; k++) begin
      cfg(MODE_PHASE_DEAD, 1'b0, 1'b1, k[0], 16'h0014, 16'h0008, 16'h0003, 16'h000a, 16'h000e);
      wait_cnt(16'h0008);
      tick(1);
      sides(1'b1, 1'b0);
      check("b phase", cb, 16'h000b);
      check("dead one", dc1, 16'h0000);
      wait_cnt(16'h000a);
      check("dead one up", dc1, 16'h0001);
      tick(1);
      sides(1'b1, 1'b1);
      check("dead one stop", dc1, 16'h0000);
      tick(1);
      sides(1'b1, 1'b0);
      check("dead two", dc2, 16'h0000);
      wait_cnt(16'h000e);
      tick(1);
      sides(1'b0, 1'b0);
    end
    done("phase dead");
    ahf = ACT_TOGGLE;
    ahs = ACT_TOGGLE;
    alf = ACT_TOGGLE;
    als = ACT_NONE;
    cfg(MODE_DEAD, 1'b0, 1'b0, 1'b1, 16'h0014, 16'h0008, 16'h000e, 16'h0001, 16'h0002);
    wait_cnt(16'h0008);
    tick(1);
    check("high at a", {14'h0000, hi, lo}, 16'h0002);
    tick(2);
    check("low at c", 16'(lo), 16'h0001);
    wait_cnt(16'h000e);
    tick(1);
    check("low none", 16'(lo), 16'h0001);
    check("dead two", dc2, 16'h0000);
    tick(3);
    check("high at d", 16'(hi), 16'h0000);
    done("variant one");
    close_out();
  end
endmodule // dtp_pwm_core_test
